// ---- sleep_wake_regs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts for the sleep/wake controller
// Assumes: Register port with byte-wide data, read data one cycle after the read strobe
// Notes:   Definitions only
`ifndef SLEEP_WAKE_REGS_SVH
`define SLEEP_WAKE_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define TIMER_OPTION_CONTROL_OFFSET 16'h0081
`define CONFIGURATION_WORD_OFFSET   16'h2007
`define SLEEP_STATUS_OFFSET         16'h0083
`define IRQ_CONTROL_OFFSET          16'h008b
`define WAKE_CAUSE_OFFSET           16'h008c

// ****************************************
// Field positions and option reset value
// ****************************************
`define OPT_PRESCALER_ASSIGN_BIT 3
`define OPT_RESET_VALUE          8'hff
`define CFG_WATCHDOG_ENABLE_BIT  3
`define CFG_XTAL_MODE_BIT        0
`define STS_POWER_DOWN_BIT       3
`define STS_TIMEOUT_BIT          4
`define IRQ_GLOBAL_ENABLE_BIT    7

// ****************************************
// Vectors and timing
// ****************************************
`define IRQ_VECTOR_ADDR   13'h0004
`define RESET_VECTOR_ADDR 13'h0000
`define OSC_STARTUP_TOSC  1024
`define CLK_PERIOD_NS     4
`define OSC_PERIOD_NS     4
`define OSC_STARTUP_CYC   ((`OSC_STARTUP_TOSC * `OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDT_TIMEOUT_CYC   4000

`endif

// ---- sleep_wake_pkg.sv ----
// Purpose: Types for the sleep/wake controller
// Assumes: Included constants header supplies all numbers
// Notes:   Types only
package sleep_wake_pkg;

  typedef enum logic [3:0] {
    ST_RUN     = 4'b0001,
    ST_SLEEP   = 4'b0010,
    ST_STARTUP = 4'b0100,
    ST_RESUME  = 4'b1000
  } pwr_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oe;
  } io_bus_type;

  typedef struct packed {
    logic        resume;
    logic        vector;
    logic [12:0] addr;
  } seq_cmd_type;

endpackage

// ---- sleep_wake_controller.sv ----
// Purpose: Sleep entry, clock stop, I/O hold and wake-up for a small core
// Assumes: Core asserts one-cycle instruction strobes; sources give level flags
// Notes:   Wake detect is combinational so it works while the core clock is gated
//
// Contract
// RQ1 - Sleep instruction enters low-power sleep
// RQ2 - Sleep clears watchdog, which keeps counting
// RQ3 - Sleep entry clears power_down_flag, sets timeout_flag
// RQ4 - Oscillator driver off while asleep
// RQ5 - I/O pins hold pre-sleep state
// RQ6 - Watchdog reset never drives master clear pin
// RQ7 - Wake on master clear, watchdog, interrupt only
// RQ8 - Master clear wake resets; others continue
// RQ9 - power_down_flag set at power-up, cleared by sleep
// RQ10 - Watchdog wake clears timeout_flag
// RQ11 - Sleep prefetches instruction at next address
// RQ12 - Interrupt wakes only if individually enabled
// RQ13 - Wake ignores global enable; clear means resume inline
// RQ14 - Global enable set: execute next, then vector 0004h
// RQ15 - Pending enabled flag at sleep wakes immediately
// RQ16 - Every wake clears the watchdog counter
// RQ17 - Crystal modes wait 1024 oscillator periods
// RQ18 - Software puts no-op after sleep if needed
// RQ19 - Watchdog timeout resets awake, wakes asleep
// RQ20 - Clear and sleep instructions clear watchdog, prescaler (prescaler_clr_o pulses only while option bit 3 is set)
// RQ21 - Wake request ORs sources, released after start-up
// RQ22 - Master clear wake restarts at reset vector
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`include "sleep_wake_regs.svh"

module sleep_wake_controller
  import sleep_wake_pkg::*;
#(
  parameter int          NUM_IRQ         = 8,
  parameter int unsigned WDT_TIMEOUT_CYC = `WDT_TIMEOUT_CYC,
  parameter int unsigned STARTUP_CYC     = `OSC_STARTUP_CYC,
  parameter logic [7:0]  CFG_DEFAULT     = 8'hff
) (
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  input  wire logic               master_clear_pin_n_i,
  input  wire logic               sleep_instr_i,
  input  wire logic               wdt_clear_instr_i,
  input  wire logic [12:0]        pc_i,
  input  wire logic [NUM_IRQ-1:0] irq_flag_i,
  input  wire logic [NUM_IRQ-1:0] irq_enable_i,
  input  wire io_bus_type         io_core_i,
  input  wire logic [15:0]        reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic [7:0]              reg_rdata_o,
  output io_bus_type              io_pin_o,
  output logic                    osc_drive_en_o,
  output logic                    core_clk_en_o,
  output logic                    core_reset_o,
  output logic                    master_clear_pin_drive_o,
  output logic                    master_clear_pin_oe_o,
  output seq_cmd_type             seq_cmd_o,
  output logic [12:0]             prefetch_addr_o,
  output logic                    prefetch_o,
  output logic                    power_down_flag_o,
  output logic                    timeout_flag_o,
  output logic                    prescaler_clr_o
);

  // ****************************************
  // Registers and state
  // ****************************************
  pwr_state_type state_ff;
  pwr_state_type nxt_state;
  logic [7:0]    option_ff;
  logic [7:0]    config_ff;
  logic          cfg_loaded_ff;
  logic          gie_ff;
  logic [31:0]   wdt_ff;
  logic [15:0]   startup_ff;
  logic [1:0]    cause_ff;
  logic          master_clear_pin_wake_ff;
  logic          irq_wake_ff;
  logic          wdt_wake_ff;

  wire logic wdt_en      = config_ff[`CFG_WATCHDOG_ENABLE_BIT];
  wire logic xtal_mode   = config_ff[`CFG_XTAL_MODE_BIT];
  wire logic wdt_expired = wdt_en && (wdt_ff >= WDT_TIMEOUT_CYC - 1);
  wire logic irq_pending = |(irq_flag_i & irq_enable_i);               // [RQ12] [RQ15]
  wire logic master_clear_pin_event  = ~master_clear_pin_n_i;
  wire logic wake_req    = master_clear_pin_event | wdt_expired | irq_pending;       // [RQ7] [RQ21]
  wire logic sys_reset   = rst_i;

  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] off);
    addr_hit = (a == off);
  endfunction

  // ****************************************
  // Power state machine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN:     if (sleep_instr_i) nxt_state = ST_SLEEP;                 // [RQ1]
      ST_SLEEP:   if (wake_req) nxt_state = ST_STARTUP;                    // [RQ7] [RQ15]
      ST_STARTUP: if (!xtal_mode || startup_ff == 16'h0000) nxt_state = ST_RESUME; // [RQ17]
      ST_RESUME:  nxt_state = ST_RUN;
      default:    nxt_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // Start-up timer
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      startup_ff <= 16'h0000;
    end else if (state_ff == ST_SLEEP && wake_req) begin
      startup_ff <= 16'(STARTUP_CYC - 1);                                   // [RQ17]
    end else if (state_ff == ST_STARTUP && startup_ff != 16'h0000) begin
      startup_ff <= startup_ff - 16'h0001;
    end
  end

  // ****************************************
  // Wake cause capture
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      master_clear_pin_wake_ff <= 1'b0;
      irq_wake_ff  <= 1'b0;
      wdt_wake_ff  <= 1'b0;
      cause_ff     <= 2'b00;
    end else if (state_ff == ST_SLEEP && wake_req) begin
      master_clear_pin_wake_ff <= master_clear_pin_event;
      wdt_wake_ff  <= ~master_clear_pin_event & wdt_expired;
      irq_wake_ff  <= ~master_clear_pin_event & ~wdt_expired & irq_pending;
      cause_ff     <= master_clear_pin_event ? 2'b01 : (wdt_expired ? 2'b10 : 2'b11);
    end
  end

  // ****************************************
  // Watchdog counter
  // ****************************************
  // Counts on the free-running clock; only the core clock is gated in sleep
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_ff <= 32'h0000_0000;
    end else if (!wdt_en) begin
      wdt_ff <= 32'h0000_0000;
    end else if (sleep_instr_i && state_ff == ST_RUN) begin
      wdt_ff <= 32'h0000_0000;                                             // [RQ2] [RQ20]
    end else if (wdt_clear_instr_i && state_ff == ST_RUN) begin
      wdt_ff <= 32'h0000_0000;                                             // [RQ20]
    end else if (state_ff == ST_SLEEP && wake_req) begin
      wdt_ff <= 32'h0000_0000;                                             // [RQ16]
    end else if (wdt_expired) begin
      wdt_ff <= 32'h0000_0000;
    end else begin
      wdt_ff <= wdt_ff + 32'h0000_0001;                                    // [RQ2]
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prescaler_clr_o <= 1'b0;
    end else begin
      prescaler_clr_o <= (sleep_instr_i | wdt_clear_instr_i) && state_ff == ST_RUN
                         && option_ff[`OPT_PRESCALER_ASSIGN_BIT];          // [RQ20]
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      power_down_flag_o <= 1'b1;                                           // [RQ9]
      timeout_flag_o    <= 1'b1;
    end else begin
      if (sleep_instr_i && state_ff == ST_RUN) begin
        power_down_flag_o <= 1'b0;                                         // [RQ3] [RQ9]
        timeout_flag_o    <= 1'b1;                                         // [RQ3]
      end else if (state_ff == ST_SLEEP && !master_clear_pin_event && wdt_expired) begin
        timeout_flag_o    <= 1'b0;                                         // [RQ10]
      end else if (state_ff == ST_RUN && wdt_expired) begin
        timeout_flag_o    <= 1'b0;
      end else if (wdt_clear_instr_i && state_ff == ST_RUN) begin
        power_down_flag_o <= 1'b1;
        timeout_flag_o    <= 1'b1;
      end
    end
  end

  // ****************************************
  // Clock, I/O hold and resets
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      osc_drive_en_o <= 1'b1;
      core_clk_en_o  <= 1'b1;
    end else begin
      osc_drive_en_o <= nxt_state != ST_SLEEP;                              // [RQ4]
      core_clk_en_o  <= nxt_state == ST_RUN || nxt_state == ST_RESUME;      // [RQ4] [RQ21]
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      io_pin_o <= '0;
    end else if (nxt_state == ST_RUN && state_ff == ST_RUN) begin
      io_pin_o <= io_core_i;
    end
    // Otherwise the last driven pattern is held, including high impedance  [RQ5]
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b1;
      master_clear_pin_drive_o <= 1'b0;
      master_clear_pin_oe_o    <= 1'b0;
    end else begin
      core_reset_o <= master_clear_pin_event && state_ff != ST_SLEEP && state_ff != ST_STARTUP
                      || (state_ff == ST_RUN && wdt_expired)                // [RQ19]
                      || (state_ff == ST_RESUME && master_clear_pin_wake_ff);           // [RQ8] [RQ22]
      master_clear_pin_drive_o <= 1'b0;                                                // [RQ6]
      master_clear_pin_oe_o    <= 1'b0;                                                // [RQ6]
    end
  end

  // ****************************************
  // Sequencer commands
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      seq_cmd_o       <= '0;
      prefetch_o      <= 1'b0;
      prefetch_addr_o <= 13'h0000;
    end else begin
      prefetch_o <= sleep_instr_i && state_ff == ST_RUN;                   // [RQ11]
      if (sleep_instr_i && state_ff == ST_RUN) begin
        prefetch_addr_o <= pc_i + 13'h0001;                                // [RQ11]
      end
      seq_cmd_o <= '0;
      if (state_ff == ST_RESUME) begin
        if (master_clear_pin_wake_ff) begin
          seq_cmd_o.addr <= `RESET_VECTOR_ADDR;                            // [RQ22]
        end else begin
          seq_cmd_o.resume <= 1'b1;                                        // [RQ8] [RQ19]
          seq_cmd_o.vector <= irq_wake_ff && gie_ff;                       // [RQ13] [RQ14]
          seq_cmd_o.addr   <= (irq_wake_ff && gie_ff) ? `IRQ_VECTOR_ADDR
                                                      : prefetch_addr_o;   // [RQ13] [RQ14]
        end
      end
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      option_ff <= `OPT_RESET_VALUE;
      gie_ff    <= 1'b0;
    end else if (reg_wr_i) begin
      if (addr_hit(reg_addr_i, `TIMER_OPTION_CONTROL_OFFSET)) begin
        option_ff <= reg_wdata_i;
      end
      if (addr_hit(reg_addr_i, `IRQ_CONTROL_OFFSET)) begin
        gie_ff <= reg_wdata_i[`IRQ_GLOBAL_ENABLE_BIT];
      end
    end
  end

  // Configuration is a strap taken once after reset release
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      config_ff     <= 8'hff;
      cfg_loaded_ff <= 1'b0;
    end else if (!cfg_loaded_ff) begin
      config_ff     <= CFG_DEFAULT;
      cfg_loaded_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (addr_hit(reg_addr_i, `TIMER_OPTION_CONTROL_OFFSET)) begin
        reg_rdata_o <= option_ff;
      end else if (addr_hit(reg_addr_i, `CONFIGURATION_WORD_OFFSET)) begin
        reg_rdata_o <= config_ff;
      end else if (addr_hit(reg_addr_i, `SLEEP_STATUS_OFFSET)) begin
        reg_rdata_o <= {3'b000, timeout_flag_o, power_down_flag_o, 3'b000};
      end else if (addr_hit(reg_addr_i, `IRQ_CONTROL_OFFSET)) begin
        reg_rdata_o <= {gie_ff, 7'h00};
      end else if (addr_hit(reg_addr_i, `WAKE_CAUSE_OFFSET)) begin
        reg_rdata_o <= {4'h0, state_ff};
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  logic unused_ok;
  assign unused_ok = sys_reset | wdt_wake_ff | (|cause_ff);

endmodule // sleep_wake_controller

// ---- sleep_wake_controller_assertions.sv ----
// Purpose: Port-level checks for the sleep/wake controller
// Assumes: Bound to every controller instance; short start-up count in tests
// Notes:   Wake bounds are loose enough for any start-up up to ten cycles
`timescale 1ns/100ps
module sleep_wake_controller_checker
  import sleep_wake_pkg::*;
#(
  parameter int NUM_IRQ = 8
) (
  input wire logic               clk_sys_i,
  input wire logic               rst_i,
  input wire logic               master_clear_pin_n_i,
  input wire logic               sleep_instr_i,
  input wire logic [12:0]        pc_i,
  input wire logic [NUM_IRQ-1:0] irq_flag_i,
  input wire logic [NUM_IRQ-1:0] irq_enable_i,
  input wire logic               reg_rd_i,
  input wire logic [7:0]         reg_rdata_o,
  input wire io_bus_type         io_pin_o,
  input wire logic               osc_drive_en_o,
  input wire logic               core_clk_en_o,
  input wire logic               core_reset_o,
  input wire logic               master_clear_pin_drive_o,
  input wire logic               master_clear_pin_oe_o,
  input wire seq_cmd_type        seq_cmd_o,
  input wire logic [12:0]        prefetch_addr_o,
  input wire logic               prefetch_o,
  input wire logic               power_down_flag_o,
  input wire logic               timeout_flag_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // Sequences
  // ****************************************
  sequence run_sleep;
    sleep_instr_i && core_clk_en_o && osc_drive_en_o && !core_reset_o;
  endsequence
  sequence asleep_pending;
    !osc_drive_en_o && (|(irq_flag_i & irq_enable_i));
  endsequence
  // ****************************************
  // Checks
  // ****************************************
  chk_sleep_stops_osc: assert property (
    run_sleep |=> !osc_drive_en_o && !core_clk_en_o)
    else $error("Sleep did not stop the oscillator");
  chk_entry_flags: assert property (
    run_sleep |=> !power_down_flag_o && timeout_flag_o && prefetch_o
      && prefetch_addr_o == $past(pc_i) + 13'h1)
    else $error("Sleep entry flags or prefetch wrong");
  chk_io_hold: assert property (!core_clk_en_o |=> $stable(io_pin_o))
    else $error("Pins moved while the core was stopped");
  chk_master_clear_pin_quiet: assert property (!master_clear_pin_oe_o && !master_clear_pin_drive_o)
    else $error("Master clear pin driven");
  chk_irq_wake: assert property (
    asleep_pending |-> ##[1:16] seq_cmd_o.resume)
    else $error("Enabled interrupt did not wake in time");
  chk_vector_addr: assert property (
    seq_cmd_o.vector |-> seq_cmd_o.resume && seq_cmd_o.addr == 13'h0004)
    else $error("Vector command with wrong address");
  chk_resume_once: assert property (seq_cmd_o.resume |=> !seq_cmd_o.resume)
    else $error("Resume command longer than one cycle");
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("Read data outside the read slot");
  chk_master_clear_pin_reset: assert property (!master_clear_pin_n_i |-> ##[1:12] core_reset_o)
    else $error("Master clear gave no core reset");
endmodule // sleep_wake_controller_checker

bind sleep_wake_controller sleep_wake_controller_checker #(.NUM_IRQ(NUM_IRQ)) checker_inst (
  .clk_sys_i, .rst_i, .master_clear_pin_n_i, .sleep_instr_i, .pc_i, .irq_flag_i, .irq_enable_i,
  .reg_rd_i, .reg_rdata_o, .io_pin_o, .osc_drive_en_o, .core_clk_en_o, .core_reset_o,
  .master_clear_pin_drive_o, .master_clear_pin_oe_o, .seq_cmd_o, .prefetch_addr_o, .prefetch_o,
  .power_down_flag_o, .timeout_flag_o);

// ---- core_seq_model.sv ----
// Purpose: Core sequencer model issuing sleep and watchdog-clear strobes
// Assumes: Bench requests sleep through sleep_req and sleep_pc
// Notes:   Pin drive keeps changing so any leak through the hold shows
`timescale 1ns/100ps
module core_seq_model
  import sleep_wake_pkg::*;
(
  input  wire logic   clk_sys_i,
  input  wire logic   rst_i,
  input  wire logic   core_clk_en_i,
  output logic        sleep_o,
  output logic        clear_o,
  output logic [12:0] pc_o,
  output io_bus_type  io_o
);
  logic        sleep_req = 1'b0;
  logic        auto_clr  = 1'b1;
  logic [12:0] sleep_pc  = 13'h0000;
  logic [7:0]  tick;
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_o <= 1'b0;
      clear_o <= 1'b0;
      pc_o    <= 13'h0000;
      tick    <= 8'h00;
      io_o    <= '0;
    end else begin
      tick    <= tick + 8'h01;
      io_o    <= {tick, ~tick};
      sleep_o <= 1'b0;
      clear_o <= 1'b0;
      pc_o    <= {5'h00, tick};
      // Nothing is issued after sleep until the clock returns
      if (core_clk_en_i && sleep_req) begin
        sleep_o   <= 1'b1;
        pc_o      <= sleep_pc;
        sleep_req <= 1'b0;
      end else if (core_clk_en_i && auto_clr && tick[3:0] == 4'h0) begin
        clear_o <= 1'b1;
      end
    end
  end
endmodule // core_seq_model

// ---- sleep_wake_controller_tb_top.sv ----
// Purpose: Self-checking bench for the sleep/wake controller
// Assumes: Watchdog shortened to 50 cycles, start-up to 8
// Notes:   Register and sleep stimulus is driven right after rising edges
`timescale 1ns/100ps
module sleep_wake_controller_tb_top;
  import sleep_wake_pkg::*;
  logic        clk_sys_i, rst_i, master_clear_pin_n_i, reg_wr_i, reg_rd_i, sleep_instr_i;
  logic        wdt_clear_instr_i, osc_drive_en_o, core_clk_en_o, core_reset_o, s;
  logic        master_clear_pin_drive_o, master_clear_pin_oe_o, prefetch_o, power_down_flag_o, timeout_flag_o;
  logic        prescaler_clr_o;
  logic [12:0] pc_i, prefetch_addr_o;
  logic [7:0]  irq_flag_i, irq_enable_i, reg_wdata_i, reg_rdata_o, rd;
  logic [15:0] reg_addr_i;
  io_bus_type  io_core_i, io_pin_o, held;
  seq_cmd_type seq_cmd_o;
  int          errors, checked, n;

  sleep_wake_controller #(.WDT_TIMEOUT_CYC(50), .STARTUP_CYC(8)) sleep_wake_controller_inst (
    .clk_sys_i, .rst_i, .master_clear_pin_n_i, .sleep_instr_i, .wdt_clear_instr_i, .pc_i, .irq_flag_i,
    .irq_enable_i, .io_core_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .io_pin_o, .osc_drive_en_o, .core_clk_en_o, .core_reset_o, .master_clear_pin_drive_o, .master_clear_pin_oe_o,
    .seq_cmd_o, .prefetch_addr_o, .prefetch_o, .power_down_flag_o, .timeout_flag_o,
    .prescaler_clr_o);
  core_seq_model core_seq_model_inst (.clk_sys_i, .rst_i, .core_clk_en_i(core_clk_en_o),
    .sleep_o(sleep_instr_i), .clear_o(wdt_clear_instr_i), .pc_o(pc_i), .io_o(io_core_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rdr(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic set_irq(input logic [7:0] en, input logic [7:0] fl);
    @(posedge clk_sys_i);
    irq_enable_i <= en;
    irq_flag_i   <= fl;
  endtask
  task automatic go_sleep(input logic [12:0] a);
    @(posedge clk_sys_i);
    core_seq_model_inst.sleep_pc  <= a;
    core_seq_model_inst.sleep_req <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  // Sel 0 prescaler clear, 1 core reset, 2 oscillator drive, 3 resume command
  task automatic watch(input int sel, input int cyc, output logic seen);
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge clk_sys_i);
      #1 seen = seen | (sel == 0 ? prescaler_clr_o : sel == 1 ? core_reset_o :
                        sel == 2 ? osc_drive_en_o : seq_cmd_o.resume);
    end
  endtask
  task automatic wait_resume(output int k);
    k = 0;
    while (seq_cmd_o.resume !== 1'b1 && k < 400) begin
      @(posedge clk_sys_i);
      #1 k++;
    end
    check("resume seen", k < 400, 1'b1);
  endtask
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Run needs under a thousand cycles; allow twenty times that
  initial begin
    #80000;
    errors++;
    close_out();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {rst_i, master_clear_pin_n_i, reg_wr_i, reg_rd_i} = 4'b1100;
    {reg_addr_i, reg_wdata_i, irq_flag_i, irq_enable_i} = '0;
    {errors, checked} = '0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rdr(16'h0081, rd); check("option reset", rd, 8'hff);
    wr(16'h0081, 8'h5a); rdr(16'h0081, rd); check("option rw", rd, 8'h5a);
    wr(16'h0081, 8'hff);
    wr(16'h2007, 8'h00); rdr(16'h2007, rd); check("config ro", rd, 8'hff);
    rdr(16'h0050, rd); check("unmapped", rd, 8'h00);
    rdr(16'h0083, rd); check("flags at power-up", rd & 8'h18, 8'h18);
    set_irq(8'h04, 8'h20);
    go_sleep(13'h0123);
    check("prefetch addr", prefetch_addr_o, 13'h0124);
    check("entry flags", {timeout_flag_o, power_down_flag_o}, 2'b10);
    check("osc off", osc_drive_en_o, 1'b0);
    held = io_pin_o;
    watch(2, 10, s); check("masked source wakes", s, 1'b0);
    check("pins held", io_pin_o, held);
    set_irq(8'h04, 8'h24);
    wait_resume(n); check("start-up wait", n >= 8, 1'b1);
    check("inline resume", seq_cmd_o.vector, 1'b0);
    set_irq(8'h00, 8'h00);
    wr(16'h008b, 8'h80);
    set_irq(8'h01, 8'h01);
    go_sleep(13'h0200);
    wait_resume(n); check("pending wakes at once", n < 20, 1'b1);
    check("vector branch", {seq_cmd_o.vector, seq_cmd_o.addr}, 14'h2004);
    set_irq(8'h00, 8'h00);
    wr(16'h008b, 8'h00);
    core_seq_model_inst.auto_clr <= 1'b0;
    go_sleep(13'h0300);
    wait_resume(n); check("watchdog wake span", n >= 40 && n <= 75, 1'b1);
    check("timeout cleared", {timeout_flag_o, power_down_flag_o}, 2'b00);
    check("no reset on wake", core_reset_o, 1'b0);
    watch(1, 20, s); check("wake clears count", s, 1'b0);
    watch(1, 60, s); check("awake timeout resets", s, 1'b1);
    core_seq_model_inst.auto_clr <= 1'b1;
    watch(0, 40, s); check("prescaler cleared", s, 1'b1);
    wr(16'h0081, 8'hf7);
    watch(0, 40, s); check("prescaler kept", s, 1'b0);
    wr(16'h0081, 8'hff);
    go_sleep(13'h0400);
    @(posedge clk_sys_i);
    master_clear_pin_n_i <= 1'b0;
    // The first reset comes out of the resume step, after the start-up wait; the pin still held low keeps it up in run
    watch(1, 14, s); check("master clear reset", s, 1'b1);
    @(posedge clk_sys_i);
    master_clear_pin_n_i <= 1'b1;
    watch(3, 20, s); check("no inline resume on clear", s, 1'b0);
    check("reset vector", seq_cmd_o.addr, 13'h0000);
    close_out();
  end
endmodule // sleep_wake_controller_tb_top
